// ===== include/umsf_defines.svh
// register offsets, field positions, reset values and trigger steps for the flow-control block
`ifndef UMSF_DEFINES_SVH
`define UMSF_DEFINES_SVH
`define UMSF_ADDR_W         3
`define UMSF_OFF_MSTAT      3'h0
`define UMSF_OFF_SCRATCH    3'h1
`define UMSF_OFF_EFEAT      3'h2
`define UMSF_OFF_MCTRL      3'h3
`define UMSF_OFF_TRIG       3'h4
`define UMSF_OFF_IMASK      3'h5
`define UMSF_OFF_ISTAT      3'h6
`define UMSF_EF_ACTS        7
`define UMSF_EF_ARTS        6
`define UMSF_EF_SW_LSB      0
`define UMSF_EF_SW_MSB      3
`define UMSF_EF_RESET       8'h00
`define UMSF_MC_RTS         1
`define UMSF_IRQ_MODEM      0
`define UMSF_IRQ_RXTRIG     1
`define UMSF_LVL_W          5
`define UMSF_TRIG_STEP      5'h04
`define UMSF_TRIG_MAX       5'h10
`endif

// ===== include/umsf_pkg.sv
// types shared by the flow-control block
package umsf_pkg;
  typedef enum logic [1:0]
  {
    UMSF_TX_IDLE = 2'b00,
    UMSF_TX_SEND = 2'b01,
    UMSF_TX_HELD = 2'b10
  } umsf_tx_e;
  typedef logic [7:0] umsf_byte_t;
endpackage

// ===== hdl/umsf_edge_sync.sv
// two-flop synchroniser with toggle detection for one modem input
module umsf_edge_sync
(
  input  wire logic clk,      // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic din,      // raw input
  output logic      dout,     // synchronised level
  output logic      toggled   // one-cycle pulse on any change
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign dout    = sync_q;
  assign toggled = sync_q ^ last_q;
endmodule

// ===== hdl/umsf_top.sv
// modem status, scratch and hardware/software flow-control registers
// Functional notes
// R1 - flag bit 1 on DSR change and bit 0 on CTS change since last read
// R2 - modem interrupt while any of status bits 0 to 3 is set
// R3 - 8-bit scratch register returns last write, no other effect
// R4 - feature bit 7 enables automatic CTS control, default off
// R5 - auto CTS: transmitter halts while CTS is 1, resumes at 0
// R6 - feature bit 6 enables automatic RTS control, default off
// R7 - auto RTS: interrupt at trigger level, RTS to 1 at next level
// R8 - auto RTS: RTS back to 0 below trigger level minus one step
// R9 - without auto RTS, RTS follows the software modem control bit
// R10 - feature low bits pick single or dual character software flow mode
// R11 - reading modem status clears all four change flags
// R12 - CTS stop waits for the character in progress to finish
// R13 - CTS and DSR synchronised; change during a read stays set
// R14 - modem interrupt drops once all change flags are clear
//
// Added by the designer: the plain strobed port and the register offsets.
`include "umsf_defines.svh"
module umsf_top
(
  input  wire logic                    clk,          // 10 MHz system clock
  input  wire logic                    rst_n,        // async reset, active low
  input  wire logic [`UMSF_ADDR_W-1:0] addr,         // register address
  input  wire logic [7:0]              wdata,        // write data
  input  wire logic                    wr,           // write strobe
  input  wire logic                    rd,           // read strobe
  output logic      [7:0]              rdata,        // read data, cycle after rd
  input  wire logic                    cts_in,       // clear-to-send, 1 = stop
  input  wire logic                    dsr_in,       // data-set-ready input
  input  wire logic                    dcd_chg,      // change pulse from DCD path
  input  wire logic                    ri_chg,       // change pulse from RI path
  input  wire logic [`UMSF_LVL_W-1:0]  rx_level,     // receive FIFO fill count
  input  wire logic                    tx_start,     // transmitter wants a character
  input  wire logic                    tx_char_done, // character finished on line
  output logic                         tx_go,        // transmitter may send
  output logic                         rts_out,      // request-to-send, 1 = stop
  output logic      [7:0]              sw_dual,      // dual-mode char pattern select
  output logic                         irq           // interrupt, active high
);
  ////////////////////////////////////////////////////////////////////////////
  logic cts_s;
  logic dsr_s;
  logic cts_tg;
  logic dsr_tg;

  umsf_edge_sync u_cts
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .din     (cts_in),
    .dout    (cts_s),
    .toggled (cts_tg)
  );

  umsf_edge_sync u_dsr
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .din     (dsr_in),
    .dout    (dsr_s),
    .toggled (dsr_tg)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]              delta_q;
  umsf_pkg::umsf_byte_t    scratch_q;
  umsf_pkg::umsf_byte_t    efeat_q;
  umsf_pkg::umsf_byte_t    mctrl_q;
  logic [`UMSF_LVL_W-1:0]  trig_q;
  logic [1:0]              imask_q;
  logic [1:0]              istat_q;
  logic [3:0]              ev_chg;
  logic                    rd_mstat;
  logic                    rd_istat;
  logic                    rx_trig_hit;
  logic                    rx_above_q;
  logic [3:0]              delta_d;
  logic [`UMSF_LVL_W:0]    trig_up;
  logic [`UMSF_LVL_W:0]    lvl_up;

  assign ev_chg   = {dcd_chg, ri_chg, dsr_tg, cts_tg};
  assign rd_mstat = rd && (addr == `UMSF_OFF_MSTAT);
  assign rd_istat = rd && (addr == `UMSF_OFF_ISTAT);
  assign delta_d  = rd_mstat ? ev_chg : (delta_q | ev_chg);
  // widened so trigger plus one step cannot wrap
  assign trig_up  = {1'b0, trig_q} + {1'b0, `UMSF_TRIG_STEP};
  assign lvl_up   = {1'b0, rx_level} + {1'b0, `UMSF_TRIG_STEP};

  // change flags: set wins over the read clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      delta_q <= 4'h0;
    else if (rd_mstat)
      delta_q <= ev_chg; // see R11 see R13
    else
      delta_q <= delta_q | ev_chg; // see R1
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scratch_q <= 8'h00;
      efeat_q   <= `UMSF_EF_RESET;
      mctrl_q   <= 8'h00;
      trig_q    <= `UMSF_TRIG_STEP;
      imask_q   <= 2'h0;
    end
    else if (wr)
    begin
      case (addr)
        `UMSF_OFF_SCRATCH: scratch_q <= wdata; // see R3
        `UMSF_OFF_EFEAT:   efeat_q   <= wdata; // see R4 see R6
        `UMSF_OFF_MCTRL:   mctrl_q   <= wdata;
        `UMSF_OFF_TRIG:    trig_q    <= wdata[`UMSF_LVL_W-1:0];
        `UMSF_OFF_IMASK:   imask_q   <= wdata[1:0];
        default:           scratch_q <= scratch_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `UMSF_OFF_MSTAT:   rdata <= {2'b00, dsr_s, cts_s, delta_q};
        `UMSF_OFF_SCRATCH: rdata <= scratch_q;
        `UMSF_OFF_EFEAT:   rdata <= efeat_q;
        `UMSF_OFF_MCTRL:   rdata <= mctrl_q;
        `UMSF_OFF_TRIG:    rdata <= {3'b000, trig_q};
        `UMSF_OFF_IMASK:   rdata <= {6'h00, imask_q};
        `UMSF_OFF_ISTAT:   rdata <= {6'h00, istat_q};
        default:           rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic prev_hit_q;
  logic [1:0] ev_irq;

  assign rx_trig_hit = (rx_level >= trig_q);
  assign ev_irq[`UMSF_IRQ_MODEM]  = |delta_d; // see R2
  assign ev_irq[`UMSF_IRQ_RXTRIG] = efeat_q[`UMSF_EF_ARTS] && rx_trig_hit && !prev_hit_q; // see R7

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_hit_q <= 1'b0;
    else
      prev_hit_q <= rx_trig_hit;
  end

  // modem bit tracks the flags so it drops when they clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      istat_q <= 2'h0;
    else
    begin
      istat_q[`UMSF_IRQ_MODEM] <= ev_irq[`UMSF_IRQ_MODEM]; // see R14
      if (rd_istat)
        istat_q[`UMSF_IRQ_RXTRIG] <= ev_irq[`UMSF_IRQ_RXTRIG];
      else
        istat_q[`UMSF_IRQ_RXTRIG] <= istat_q[`UMSF_IRQ_RXTRIG] | ev_irq[`UMSF_IRQ_RXTRIG];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
    begin
      irq <= |({(istat_q[1] && !rd_istat) || ev_irq[1], ev_irq[0]} & imask_q); // see R2 see R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rts: hysteresis between next level and trigger minus one step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_above_q <= 1'b0;
    else if (!efeat_q[`UMSF_EF_ARTS])
      rx_above_q <= 1'b0;
    else if ({1'b0, rx_level} >= trig_up)
      rx_above_q <= 1'b1; // see R7
    else if (lvl_up < {1'b0, trig_q})
      rx_above_q <= 1'b0; // see R8
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rts_out <= 1'b1;
    else if (efeat_q[`UMSF_EF_ARTS])
      rts_out <= rx_above_q;
    else
      rts_out <= !mctrl_q[`UMSF_MC_RTS]; // see R9
  end

  // dual pattern: resume chars then pause chars sent back to back
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_dual <= 8'h00;
    else
    begin
      sw_dual[0] <= efeat_q[3] && efeat_q[2]; // see R10
      sw_dual[1] <= efeat_q[1] && efeat_q[0]; // see R10
      sw_dual[7:2] <= {2'b00, efeat_q[`UMSF_EF_SW_MSB:`UMSF_EF_SW_LSB]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  umsf_pkg::umsf_tx_e tx_st_q;
  logic cts_hold;

  assign cts_hold = efeat_q[`UMSF_EF_ACTS] && cts_s; // see R4 see R5

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_st_q <= umsf_pkg::UMSF_TX_IDLE;
    else
    begin
      case (tx_st_q)
        umsf_pkg::UMSF_TX_IDLE:
          if (cts_hold)
            tx_st_q <= umsf_pkg::UMSF_TX_HELD; // see R5
          else if (tx_start)
            tx_st_q <= umsf_pkg::UMSF_TX_SEND;
        umsf_pkg::UMSF_TX_SEND:
          if (tx_char_done)
            tx_st_q <= cts_hold ? umsf_pkg::UMSF_TX_HELD : umsf_pkg::UMSF_TX_IDLE; // see R12
        umsf_pkg::UMSF_TX_HELD:
          if (!cts_hold)
            tx_st_q <= umsf_pkg::UMSF_TX_IDLE; // see R5
        default:
          tx_st_q <= umsf_pkg::UMSF_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_go <= 1'b0;
    else
      tx_go <= !cts_hold || (tx_st_q == umsf_pkg::UMSF_TX_SEND); // see R12
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  dsr_flag_set_a: assert property (dsr_tg |=> delta_q[1]) // see R1
    else $error("dsr change not flagged");
  cts_flag_set_a: assert property (cts_tg |=> delta_q[0]) // see R1
    else $error("cts change not flagged");
  read_clears_a: assert property (rd_mstat && !(|ev_chg) |=> delta_q == 4'h0) // see R11
    else $error("status read left flags set");
  read_keeps_a: assert property (rd_mstat && cts_tg |=> delta_q[0]) // see R13
    else $error("change lost during read");
  modem_irq_a: assert property (imask_q[0] && |delta_q && !rd_mstat |=> irq) // see R2
    else $error("modem interrupt missing");
  irq_drop_a: assert property (delta_q == 4'h0 && !(|ev_chg) && imask_q == 2'b01 |=> !irq) // see R14
    else $error("modem interrupt stuck");
  sequence scratch_wr_s;
    wr && addr == `UMSF_OFF_SCRATCH;
  endsequence
  sequence scratch_rd_s;
    rd && addr == `UMSF_OFF_SCRATCH;
  endsequence
  scratch_hold_a: assert property (scratch_wr_s ##1 scratch_rd_s // see R3
    |=> rdata == $past(wdata, 2))
    else $error("scratch readback wrong");
  rts_manual_a: assert property (!efeat_q[6] ##1 !efeat_q[6] |=> rts_out == !$past(mctrl_q[1])) // see R9
    else $error("manual rts wrong");
  cts_halt_a: assert property (cts_hold && tx_st_q == umsf_pkg::UMSF_TX_HELD |=> !tx_go) // see R5
    else $error("tx not halted");
  char_finish_a: assert property (tx_st_q == umsf_pkg::UMSF_TX_SEND |=> tx_go) // see R12
    else $error("character cut short");
  rts_high_a: assert property (efeat_q[6] && rx_above_q |=> rts_out) // see R7
    else $error("rts not raised");
  rts_low_a: assert property (efeat_q[6] && !rx_above_q |=> !rts_out) // see R8
    else $error("rts not released");
  acts_off_a: assert property (!efeat_q[`UMSF_EF_ACTS] |=> tx_go) // see R4
    else $error("tx held with auto cts off");
  rx_irq_set_a: assert property (ev_irq[`UMSF_IRQ_RXTRIG] |=> istat_q[`UMSF_IRQ_RXTRIG]) // see R7
    else $error("trigger status lost");
  modem_mirror_a: assert property (istat_q[`UMSF_IRQ_MODEM] == |delta_q) // see R14
    else $error("modem status bit out of step");
  cts_sync_a: assert property (cts_s == $past(cts_in, 2)) // see R13
    else $error("cts sync delay wrong");
endmodule

// ===== testbench/umsf_modem_model.sv
// modem-side model driving the handshake inputs
module umsf_modem_model
(
  input  wire logic clk,    // system clock
  output logic      cts_in, // clear-to-send, 1 = stop
  output logic      dsr_in  // data-set-ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cts_in = 1'b0;
    dsr_in = 1'b0;
  end
  // levels change just after an edge and hold until told otherwise
  task automatic set_lines(input logic cts, input logic dsr);
    @(posedge clk);
    cts_in <= cts;
    dsr_in <= dsr;
  endtask
endmodule

// ===== testbench/umsf_top_bench.sv
// self-checking bench for the modem status and flow-control block
`include "umsf_defines.svh"
module umsf_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk;
  logic                    rst_n;
  logic [`UMSF_ADDR_W-1:0] addr;
  logic [7:0]              wdata;
  logic                    wr;
  logic                    rd;
  logic [7:0]              rdata;
  logic                    cts_in;
  logic                    dsr_in;
  logic                    dcd_chg;
  logic                    ri_chg;
  logic [`UMSF_LVL_W-1:0]  rx_level;
  logic                    tx_start;
  logic                    tx_char_done;
  logic                    tx_go;
  logic                    rts_out;
  logic [7:0]              sw_dual;
  logic                    irq;
  int                      n_fail;
  int                      n_compared;
  umsf_top umsf_top_inst
  (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cts_in(cts_in), .dsr_in(dsr_in), .dcd_chg(dcd_chg),
    .ri_chg(ri_chg), .rx_level(rx_level), .tx_start(tx_start),
    .tx_char_done(tx_char_done), .tx_go(tx_go), .rts_out(rts_out),
    .sw_dual(sw_dual), .irq(irq)
  );
  umsf_modem_model umsf_modem_model_inst
  (
    .clk(clk), .cts_in(cts_in), .dsr_in(dsr_in)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp, what);
  endtask
  task automatic pulse(input logic done, input int gap);
    @(posedge clk);
    tx_char_done <= done;
    tx_start     <= !done;
    @(posedge clk);
    tx_char_done <= 1'b0;
    tx_start     <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
  task automatic lines(input logic c, input logic d);
    umsf_modem_model_inst.set_lines(c, d);
    repeat (5) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(`UMSF_OFF_EFEAT, `UMSF_EF_RESET, "feature reset");
    wr_reg(`UMSF_OFF_SCRATCH, 8'ha5);
    wr_reg(`UMSF_OFF_SCRATCH, 8'h5a);
    rd_chk(`UMSF_OFF_SCRATCH, 8'h5a, "scratch");
    chk({7'h00, rts_out}, 8'h01, "scratch side effect");
    @(posedge clk);
    addr  <= `UMSF_OFF_SCRATCH;
    wdata <= 8'h3c;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, 8'h3c, "write then read");
    rd_chk(3'h7, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_modem;
    wr_reg(`UMSF_OFF_IMASK, 8'h01);
    lines(1'b1, 1'b0);
    chk({7'h00, irq}, 8'h01, "irq set");
    rd_chk(`UMSF_OFF_MSTAT, 8'h11, "cts flag");
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00, "irq drop");
    rd_chk(`UMSF_OFF_MSTAT, 8'h10, "read clear");
    @(posedge clk);
    dcd_chg <= 1'b1;
    ri_chg  <= 1'b1;
    @(posedge clk);
    dcd_chg <= 1'b0;
    ri_chg  <= 1'b0;
    lines(1'b1, 1'b1);
    rd_chk(`UMSF_OFF_MSTAT, 8'h3e, "dsr dcd ri flags");
    rd_chk(`UMSF_OFF_MSTAT, 8'h30, "all cleared");
    $display("test modem done");
  endtask
  task automatic t_cts;
    chk({7'h00, tx_go}, 8'h01, "auto cts off");
    wr_reg(`UMSF_OFF_EFEAT, 8'h80);
    repeat (3) @(posedge clk);
    chk({7'h00, tx_go}, 8'h00, "halt");
    lines(1'b0, 1'b1);
    chk({7'h00, tx_go}, 8'h01, "resume");
    pulse(1'b0, 2);
    lines(1'b1, 1'b1);
    chk({7'h00, tx_go}, 8'h01, "char in flight");
    pulse(1'b1, 2);
    chk({7'h00, tx_go}, 8'h00, "stop after char");
    lines(1'b0, 1'b1);
    chk({7'h00, tx_go}, 8'h01, "resume again");
    rd_chk(`UMSF_OFF_MSTAT, 8'h21, "cts flag again");
    $display("test cts done");
  endtask
  task automatic t_rts;
    int lvl[5] = '{0, 11, 12, 4, 3};
    logic [7:0] exp[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    wr_reg(`UMSF_OFF_TRIG, 8'h08);
    wr_reg(`UMSF_OFF_IMASK, 8'h02);
    wr_reg(`UMSF_OFF_EFEAT, 8'h40);
    for (int i = 0; i < 5; i++)
    begin
      rx_level <= lvl[i][4:0];
      repeat (4) @(posedge clk);
      chk({7'h00, rts_out}, exp[i], "auto rts");
      if (i == 1)
        chk({7'h00, irq}, 8'h01, "trigger irq");
    end
    rd_chk(`UMSF_OFF_ISTAT, 8'h02, "trigger status");
    rd_chk(`UMSF_OFF_ISTAT, 8'h00, "status cleared");
    @(posedge clk);
    rx_level <= 5'h10;
    wr_reg(`UMSF_OFF_EFEAT, 8'h00);
    wr_reg(`UMSF_OFF_MCTRL, 8'h02);
    repeat (3) @(posedge clk);
    chk({7'h00, rts_out}, 8'h00, "manual rts");
    wr_reg(`UMSF_OFF_MCTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h00, rts_out}, 8'h01, "manual rts off");
    $display("test rts done");
  endtask
  task automatic t_sw;
    logic [7:0] mode[4] = '{8'h0f, 8'h08, 8'h0b, 8'h0c};
    logic [7:0] exp[4] = '{8'h3f, 8'h20, 8'h2e, 8'h31};
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(`UMSF_OFF_EFEAT, mode[i]);
      repeat (2) @(posedge clk);
      chk(sw_dual, exp[i], "sw flow mode");
    end
    $display("test sw done");
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial
  begin
    {rst_n, wr, rd, dcd_chg, ri_chg, tx_start, tx_char_done} = '0;
    {addr, wdata, rx_level} = '0;
    repeat (20) @(posedge clk);
    chk({6'h00, rts_out, tx_go}, 8'h02, "reset outputs");
    chk({7'h00, irq}, 8'h00, "reset irq");
    chk(sw_dual | rdata, 8'h00, "reset data");
    rst_n <= 1'b1;
    t_regs;
    t_modem;
    t_cts;
    t_rts;
    t_sw;
    complete_run;
  end
endmodule
